// ==== port_int_regs.svh ====
// Purpose: Offsets, field layouts and reset values of the port integration block
// Assumes: Byte-wide registers on a 10-bit register address
// Notes: Definitions only
`ifndef PORT_INT_REGS_SVH
`define PORT_INT_REGS_SVH

// Register offsets
`define PORT_D_DATA_OFS 10'h005
`define PORT_C_DIR_OFS 10'h006
`define PORT_D_DIR_OFS 10'h007
`define RSVD_LOW_FIRST_OFS 10'h008
`define RSVD_LOW_LAST_OFS 10'h019
`define PORT_A_SAMPLE_OFS 10'h120
`define RSVD_SINGLE_OFS 10'h121
`define PORT_A_DRIVE_OFS 10'h122

// Field widths
`define PORT_A_PINS 6
`define PORT_C_PINS 2
`define PORT_D_PINS 8
`define REG_ADDR_W 10
`define REG_DATA_W 8

// Reset values
`define PORT_D_DATA_RST 8'h00
`define PORT_D_DIR_RST 8'h00
`define PORT_C_DIR_RST 2'h0
`define PORT_A_DRIVE_RST 6'h00
`define REG_RDATA_RST 8'h00

// Die link data lane masks
`define LINK_WIDE_MASK 8'hFF
`define LINK_NARROW_MASK 8'h0F
`define LINK_NONE_MASK 8'h00

// Port C pin roles under the die link
`define PC_LINK_CLK_BIT 0
`define PC_LINK_INT_BIT 1

`endif

// ==== port_types_pkg.sv ====
// Purpose: Types shared by the port integration block
// Assumes: Nothing beyond the register header
// Notes: Register select used by decode and read mux
package port_types_pkg;

  typedef enum {
    SEL_NONE,
    SEL_PD_DATA,
    SEL_PD_DIR,
    SEL_PC_DIR,
    SEL_PA_SAMPLE,
    SEL_PA_DRIVE
  } reg_sel_t;

  typedef logic [9:0] reg_addr_t;
  typedef logic [7:0] reg_byte_t;

endpackage

// ==== pin_sync_if.sv ====
// Purpose: Carries raw pin levels to the synchroniser and synced levels back
// Assumes: One clock domain on the synced side
// Notes: Width set by the instantiating module
interface pin_sync_if #(parameter int WIDTH = 16);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] synced;

  modport user
  (
    output raw,
    input synced
  );

  modport sync
  (
    input raw,
    output synced
  );
endinterface

// ==== pin_level_sync.sv ====
// Purpose: Two-stage synchroniser for pin input levels
// Assumes: Pins are asynchronous to the core clock
// Notes: No reset, so sampled levels are never forced
module pin_level_sync #(parameter int WIDTH = 16)
(
  // Clock
  input wire logic I_CORE_CLK,
  // Pin levels
  pin_sync_if.sync pins
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] stable_q;
  logic [WIDTH-1:0] stable_d;

  always_comb
  begin
    meta_d = pins.raw;
    stable_d = meta_q;
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    meta_q <= meta_d;
    stable_q <= stable_d;
  end

  assign pins.synced = stable_q;

  property p_sync_delay;
    @(posedge I_CORE_CLK) ##2 1 |-> (pins.synced == $past(pins.raw, 2));
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("Synchroniser delay is not two cycles");

endmodule

// ==== port_integration_registers.sv ====
// Purpose: Port D data, port C and D direction, port A sample and drive registers
// Assumes: Die link interface and port A/C data logic sit outside on the same clock
// Notes: Read data appear in the cycle after the read strobe only
`include "port_int_regs.svh"

// Function
// - Port D data read returns register where direction is one, else synced pin
// - Die link in wide mode owns all eight port D pins
// - Die link in narrow mode owns port D pins 3..0 only
// - Unclaimed port D pins work as plain I/O from data and direction
// - Port C direction register holds two bits, one per pin
// - Port D direction register holds eight bits, one per pin
// - Die link decides claimed pin direction; stored direction bits untouched
// - Direction one drives the pin; zero leaves it a high-impedance input
// - Reserved locations read zero and ignore writes
// - Port A sample register reads synced pins 5..0, read-only
// - Port A sample contents are not forced by reset
// - Drive bit one selects one-sixth drive; zero selects full drive
// - Drive bit has no effect while its pin is an input
// - Pull-downs on port D pins the die link uses as inputs
// - Port C pin 1 is link interrupt input, pin 0 link clock output
module port_integration_registers
(
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_SYS_RST,
  // Register port
  input wire logic [9:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  output logic [7:0] O_REG_RDATA,
  // Port A
  input wire logic [5:0] I_PA_PIN,
  input wire logic [5:0] I_PA_OE,
  output logic [5:0] O_PA_REDUCED_DRIVE,
  // Port C
  input wire logic [1:0] I_PC_PIN,
  input wire logic [1:0] I_PC_DATA,
  output logic [1:0] O_PC_OUT,
  output logic [1:0] O_PC_OE,
  output logic [1:0] O_PC_PULL_DOWN,
  // Port D
  input wire logic [7:0] I_PD_PIN,
  output logic [7:0] O_PD_OUT,
  output logic [7:0] O_PD_OE,
  output logic [7:0] O_PD_PULL_DOWN,
  // Die link interface
  input wire logic I_DIE_LINK_EN,
  input wire logic I_DIE_LINK_WIDE,
  input wire logic [7:0] I_DIE_LINK_DATA_OUT,
  input wire logic [7:0] I_DIE_LINK_DATA_OE,
  output logic [7:0] O_DIE_LINK_DATA_IN,
  input wire logic I_DIE_LINK_CLOCK_OUT,
  output logic O_DIE_LINK_INTERRUPT_IN
);

  localparam int SYNC_W = `PORT_C_PINS + `PORT_A_PINS + `PORT_D_PINS;

  function automatic port_types_pkg::reg_sel_t reg_decode(input logic [9:0] addr);
    port_types_pkg::reg_sel_t sel;
    sel = port_types_pkg::SEL_NONE;
    case (addr)
      `PORT_D_DATA_OFS: sel = port_types_pkg::SEL_PD_DATA;
      `PORT_D_DIR_OFS: sel = port_types_pkg::SEL_PD_DIR;
      `PORT_C_DIR_OFS: sel = port_types_pkg::SEL_PC_DIR;
      `PORT_A_SAMPLE_OFS: sel = port_types_pkg::SEL_PA_SAMPLE;
      `PORT_A_DRIVE_OFS: sel = port_types_pkg::SEL_PA_DRIVE;
      default: sel = port_types_pkg::SEL_NONE;
    endcase
    return sel;
  endfunction

  function automatic logic [7:0] link_claim(input logic en, input logic wide);
    logic [7:0] mask;
    mask = `LINK_NONE_MASK;
    if (en)
    begin
      mask = wide ? `LINK_WIDE_MASK : `LINK_NARROW_MASK;
    end
    return mask;
  endfunction

  function automatic logic [7:0] mixed_read(input logic [7:0] dir, input logic [7:0] stored,
                                            input logic [7:0] pin);
    return (dir & stored) | (~dir & pin);
  endfunction

  // Synchronised pins
  pin_sync_if #(.WIDTH(SYNC_W)) pins_if ();
  logic [7:0] pd_sync;
  logic [5:0] pa_sync;
  logic [1:0] pc_sync;

  assign pins_if.raw = {I_PC_PIN, I_PA_PIN, I_PD_PIN};

  pin_level_sync #(.WIDTH(SYNC_W)) u_sync
  (
    .I_CORE_CLK(I_CORE_CLK),
    .pins(pins_if.sync)
  );

  assign pd_sync = pins_if.synced[7:0];
  assign pa_sync = pins_if.synced[13:8];
  assign pc_sync = pins_if.synced[15:14];

  // Register state
  port_types_pkg::reg_sel_t sel;
  logic [7:0] pd_data_q;
  logic [7:0] pd_data_d;
  logic [7:0] pd_dir_q;
  logic [7:0] pd_dir_d;
  logic [1:0] pc_dir_q;
  logic [1:0] pc_dir_d;
  logic [5:0] pa_drive_q;
  logic [5:0] pa_drive_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  assign sel = reg_decode(I_REG_ADDR);

  always_comb
  begin
    pd_data_d = pd_data_q;
    pd_dir_d = pd_dir_q;
    pc_dir_d = pc_dir_q;
    pa_drive_d = pa_drive_q;
    rdata_d = `REG_RDATA_RST;
    // Reserved and unmapped offsets fall to no select: writes dropped
    if (I_REG_WR)
    begin
      case (sel)
        port_types_pkg::SEL_PD_DATA: pd_data_d = I_REG_WDATA;
        port_types_pkg::SEL_PD_DIR: pd_dir_d = I_REG_WDATA;
        port_types_pkg::SEL_PC_DIR: pc_dir_d = I_REG_WDATA[1:0];
        port_types_pkg::SEL_PA_DRIVE: pa_drive_d = I_REG_WDATA[5:0];
        default: pd_data_d = pd_data_q;
      endcase
    end
    if (I_REG_RD)
    begin
      case (sel)
        port_types_pkg::SEL_PD_DATA: rdata_d = mixed_read(pd_dir_q, pd_data_q, pd_sync);
        port_types_pkg::SEL_PD_DIR: rdata_d = pd_dir_q;
        port_types_pkg::SEL_PC_DIR: rdata_d = {6'h00, pc_dir_q};
        port_types_pkg::SEL_PA_SAMPLE: rdata_d = {2'h0, pa_sync};
        port_types_pkg::SEL_PA_DRIVE: rdata_d = {2'h0, pa_drive_q};
        default: rdata_d = `REG_RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      pd_data_q <= `PORT_D_DATA_RST;
      pd_dir_q <= `PORT_D_DIR_RST;
      pc_dir_q <= `PORT_C_DIR_RST;
      pa_drive_q <= `PORT_A_DRIVE_RST;
      rdata_q <= `REG_RDATA_RST;
    end
    else
    begin
      pd_data_q <= pd_data_d;
      pd_dir_q <= pd_dir_d;
      pc_dir_q <= pc_dir_d;
      pa_drive_q <= pa_drive_d;
      rdata_q <= rdata_d;
    end
  end

  assign O_REG_RDATA = rdata_q;

  // Pin muxing
  logic [7:0] claim;

  assign claim = link_claim(I_DIE_LINK_EN, I_DIE_LINK_WIDE);

  always_comb
  begin
    // Claimed lanes follow the link, the rest follow data and direction
    O_PD_OE = (claim & I_DIE_LINK_DATA_OE) | (~claim & pd_dir_q);
    O_PD_OUT = (claim & I_DIE_LINK_DATA_OUT) | (~claim & pd_data_q);
    O_PD_PULL_DOWN = claim & ~I_DIE_LINK_DATA_OE;
    O_DIE_LINK_DATA_IN = pd_sync & claim;
    if (I_DIE_LINK_EN)
    begin
      O_PC_OE = 2'h1;
      O_PC_OUT = {1'b0, I_DIE_LINK_CLOCK_OUT};
      O_PC_PULL_DOWN = 2'h2;
    end
    else
    begin
      O_PC_OE = pc_dir_q;
      O_PC_OUT = I_PC_DATA;
      O_PC_PULL_DOWN = 2'h0;
    end
    O_DIE_LINK_INTERRUPT_IN = I_DIE_LINK_EN & pc_sync[`PC_LINK_INT_BIT];
    O_PA_REDUCED_DRIVE = pa_drive_q & I_PA_OE;
  end

  // Checks
  property p_pd_read;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (I_REG_RD && sel == port_types_pkg::SEL_PD_DATA) |=>
        (O_REG_RDATA == (($past(pd_dir_q) & $past(pd_data_q)) | (~$past(pd_dir_q) & $past(pd_sync))));
  endproperty
  a_pd_read: assert property (p_pd_read) else $error("Port D data read mixes wrong sources");

  property p_wide_claim;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (I_DIE_LINK_EN && I_DIE_LINK_WIDE) |-> (O_PD_OE == I_DIE_LINK_DATA_OE && O_PD_OUT == I_DIE_LINK_DATA_OUT);
  endproperty
  a_wide_claim: assert property (p_wide_claim) else $error("Wide link does not own all port D pins");

  property p_narrow_claim;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (I_DIE_LINK_EN && !I_DIE_LINK_WIDE) |->
        (O_PD_OE[3:0] == I_DIE_LINK_DATA_OE[3:0] && O_PD_OE[7:4] == pd_dir_q[7:4]
         && O_PD_OUT[7:4] == pd_data_q[7:4]);
  endproperty
  a_narrow_claim: assert property (p_narrow_claim) else $error("Narrow link lane split wrong");

  property p_gpio_dir;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      !I_DIE_LINK_EN |-> (O_PD_OE == pd_dir_q && O_PD_OUT == pd_data_q && O_PC_OE == pc_dir_q);
  endproperty
  a_gpio_dir: assert property (p_gpio_dir) else $error("Plain pins do not follow direction");

  property p_dir_hold;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      !(I_REG_WR && (sel == port_types_pkg::SEL_PD_DIR || sel == port_types_pkg::SEL_PC_DIR)) |=>
        ($stable(pd_dir_q) && $stable(pc_dir_q));
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("Direction bits changed without a write");

  property p_pc_dir_write;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (I_REG_WR && sel == port_types_pkg::SEL_PC_DIR) |=> (pc_dir_q == $past(I_REG_WDATA[1:0]));
  endproperty
  a_pc_dir_write: assert property (p_pc_dir_write) else $error("Port C direction write lost");

  property p_pd_dir_write;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (I_REG_WR && sel == port_types_pkg::SEL_PD_DIR) ##1 I_REG_RD && sel == port_types_pkg::SEL_PD_DIR |=>
        (O_REG_RDATA == $past(I_REG_WDATA, 2));
  endproperty
  a_pd_dir_write: assert property (p_pd_dir_write) else $error("Port D direction write not read back");

  property p_rsvd_read;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (I_REG_RD && (I_REG_ADDR == `RSVD_SINGLE_OFS
       || (I_REG_ADDR >= `RSVD_LOW_FIRST_OFS && I_REG_ADDR <= `RSVD_LOW_LAST_OFS))) |=> (O_REG_RDATA == 8'h00);
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("Reserved location read not zero");

  property p_sample_read;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (I_REG_RD && sel == port_types_pkg::SEL_PA_SAMPLE) |=> (O_REG_RDATA == {2'h0, $past(I_PA_PIN, 3)});
  endproperty
  a_sample_read: assert property (p_sample_read) else $error("Port A sample not synced pin level");

  property p_drive;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (I_REG_WR && sel == port_types_pkg::SEL_PA_DRIVE) |=>
        (O_PA_REDUCED_DRIVE == ($past(I_REG_WDATA[5:0]) & I_PA_OE));
  endproperty
  a_drive: assert property (p_drive) else $error("Reduced drive not gated by output use");

  property p_pull_down;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (I_DIE_LINK_EN && I_DIE_LINK_WIDE && I_DIE_LINK_DATA_OE == 8'h00) |-> (O_PD_PULL_DOWN == 8'hFF);
  endproperty
  a_pull_down: assert property (p_pull_down) else $error("Link input pins lack pull-down");

  property p_pc_link;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      I_DIE_LINK_EN |-> (O_PC_OE == 2'h1 && O_PC_OUT[0] == I_DIE_LINK_CLOCK_OUT && O_PC_PULL_DOWN[1]);
  endproperty
  a_pc_link: assert property (p_pc_link) else $error("Port C link roles wrong");

  property p_link_off_quiet;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      !I_DIE_LINK_EN |-> (O_PD_PULL_DOWN == 8'h00 && O_PC_PULL_DOWN == 2'h0
        && O_DIE_LINK_DATA_IN == 8'h00 && !O_DIE_LINK_INTERRUPT_IN);
  endproperty
  a_link_off_quiet: assert property (p_link_off_quiet) else $error("Plain pins show link pull or data");

  property p_narrow_upper;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (I_DIE_LINK_EN && !I_DIE_LINK_WIDE) |-> (O_DIE_LINK_DATA_IN[7:4] == 4'h0 && O_PD_PULL_DOWN[7:4] == 4'h0);
  endproperty
  a_narrow_upper: assert property (p_narrow_upper) else $error("Narrow link touches upper pins");

  property p_ignored_write;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (I_REG_WR && (sel == port_types_pkg::SEL_NONE || sel == port_types_pkg::SEL_PA_SAMPLE)) |=>
        ($stable(pd_data_q) && $stable(pd_dir_q) && $stable(pc_dir_q) && $stable(pa_drive_q));
  endproperty
  a_ignored_write: assert property (p_ignored_write) else $error("Ignored write changed a register");

  property p_pd_data_write;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (I_REG_WR && sel == port_types_pkg::SEL_PD_DATA) |=>
        ((O_PD_OUT & ~claim) == ($past(I_REG_WDATA) & ~claim));
  endproperty
  a_pd_data_write: assert property (p_pd_data_write) else $error("Plain port D pins miss data write");

endmodule

// ==== pin_far_model.sv ====
// Purpose: Pin level model for port D and port C lines
// Assumes: Bits 9:8 are port C, bits 7:0 port D
// Notes: Undriven lines without pull-down toggle every cycle
module pin_far_model
(
  // Clock
  input wire logic i_clk,
  // Block side
  input wire logic [9:0] i_out,
  input wire logic [9:0] i_oe,
  input wire logic [9:0] i_pull,
  // Far side
  input wire logic [9:0] i_ext,
  input wire logic [9:0] i_ext_en,
  output logic [9:0] o_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] float_q = 10'h155;
  always @(posedge i_clk)
    float_q <= ~float_q;
  // Block wins, then far drive, then pull-down, else floating
  always_comb
    o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext) | (~i_oe & ~i_ext_en & ~i_pull & float_q);
endmodule

// ==== test_port_integration_registers.sv ====
// Purpose: Self-checking bench for the port integration registers
// Assumes: Read data checked in the cycle after each read strobe
// Notes: Expected read values queued by the driver
`include "port_int_regs.svh"
module test_port_integration_registers;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_seen = 1'b0;
  logic [7:0] rdata, pd_out, pd_oe, pd_pd, link_in;
  logic [7:0] link_out = 8'h00;
  logic [7:0] link_oe = 8'h00;
  logic [5:0] pa_pin = 6'h00;
  logic [5:0] pa_oe = 6'h00;
  logic [5:0] pa_red;
  logic [1:0] pc_data = 2'h0;
  logic [1:0] pc_out, pc_oe, pc_pd;
  logic link_en = 1'b0;
  logic link_wide = 1'b0;
  logic link_clk = 1'b0;
  logic link_int;
  logic [9:0] ext = 10'h000;
  logic [9:0] ext_en = 10'h3FF;
  wire [9:0] far_pin;
  logic [7:0] exp_q[$];
  logic [9:0] rsv[4] = '{`RSVD_LOW_FIRST_OFS, `RSVD_LOW_LAST_OFS, `RSVD_SINGLE_OFS, 10'h3FF};
  int err_total = 0;
  int checked = 0;
  int cycles = 0;

  always #2 clk = ~clk;

  port_integration_registers u_dut
  (
    .I_CORE_CLK(clk), .I_SYS_RST(rst), .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .I_REG_WR(wr),
    .I_REG_RD(rd), .O_REG_RDATA(rdata), .I_PA_PIN(pa_pin), .I_PA_OE(pa_oe), .O_PA_REDUCED_DRIVE(pa_red),
    .I_PC_PIN(far_pin[9:8]), .I_PC_DATA(pc_data), .O_PC_OUT(pc_out), .O_PC_OE(pc_oe),
    .O_PC_PULL_DOWN(pc_pd), .I_PD_PIN(far_pin[7:0]), .O_PD_OUT(pd_out), .O_PD_OE(pd_oe),
    .O_PD_PULL_DOWN(pd_pd), .I_DIE_LINK_EN(link_en), .I_DIE_LINK_WIDE(link_wide),
    .I_DIE_LINK_DATA_OUT(link_out), .I_DIE_LINK_DATA_OE(link_oe), .O_DIE_LINK_DATA_IN(link_in),
    .I_DIE_LINK_CLOCK_OUT(link_clk), .O_DIE_LINK_INTERRUPT_IN(link_int)
  );

  pin_far_model u_far
  (
    .i_clk(clk), .i_out({pc_out, pd_out}), .i_oe({pc_oe, pd_oe}), .i_pull({pc_pd, pd_pd}),
    .i_ext(ext), .i_ext_en(ext_en), .o_pin(far_pin)
  );

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_read(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    rd <= 1'b0;
    wr <= 1'b1;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [9:0] a, input logic [7:0] e);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
  endtask

  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask

  task automatic settle();
    idle(1);
    @(negedge clk);
  endtask

  // Read results and the idle level of the read bus
  always @(posedge clk)
  begin
    rd_seen <= rd;
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  always @(negedge clk)
    if (rd_seen)
      check_read("read data", exp_q.pop_front(), rdata);
    else if (!rst)
      check_read("idle read data", 8'h00, rdata);

  initial
  begin
    logic [7:0] v, m, p, lo, le, mk, eoe, eo;
    // Reset edge at time zero so no register except the synchroniser stages starts unknown
    rst <= 1'b1;
    void'($urandom(32'h33C0));
    v = 8'h00;
    m = 8'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    idle(3);
    rd_reg(`PORT_D_DATA_OFS, 8'h00);
    rd_reg(`PORT_C_DIR_OFS, 8'h00);
    rd_reg(`PORT_D_DIR_OFS, 8'h00);
    rd_reg(`PORT_A_DRIVE_OFS, 8'h00);
    wr_reg(`PORT_C_DIR_OFS, 8'hFF);
    wr_reg(`PORT_A_DRIVE_OFS, 8'hFF);
    rd_reg(`PORT_C_DIR_OFS, 8'h03);
    rd_reg(`PORT_A_DRIVE_OFS, 8'h3F);
    foreach (rsv[i])
    begin
      wr_reg(rsv[i], 8'hFF);
      rd_reg(rsv[i], 8'h00);
    end
    rd_reg(`PORT_A_DRIVE_OFS, 8'h3F);
    repeat (4)
    begin
      v = 8'($urandom);
      pa_oe <= 6'($urandom);
      wr_reg(`PORT_A_DRIVE_OFS, v);
      settle();
      check("reduced drive", {2'h0, v[5:0] & pa_oe}, {2'h0, pa_red});
      @(posedge clk);
    end
    repeat (4)
    begin
      v = 8'($urandom);
      m = 8'($urandom);
      p = 8'($urandom);
      ext[7:0] <= p;
      ext_en[7:0] <= ~m;
      wr_reg(`PORT_D_DATA_OFS, v);
      wr_reg(`PORT_D_DIR_OFS, m);
      rd_reg(`PORT_D_DIR_OFS, m);
      idle(2);
      rd_reg(`PORT_D_DATA_OFS, (m & v) | (~m & p));
      settle();
      check("port d enable", m, pd_oe);
      check("port d out", m & v, m & pd_out);
      @(posedge clk);
    end
    pc_data <= 2'($urandom);
    for (int w = 1; w >= 0; w--)
    begin
      mk = (w == 1) ? `LINK_WIDE_MASK : `LINK_NARROW_MASK;
      m = 8'($urandom);
      p = 8'($urandom);
      lo = 8'($urandom);
      le = 8'($urandom);
      eoe = (mk & le) | (~mk & m);
      eo = (mk & lo) | (~mk & v);
      link_en <= 1'b1;
      link_wide <= w[0];
      link_out <= lo;
      link_oe <= le;
      link_clk <= w[0];
      ext <= {p[0], 1'b0, p};
      ext_en <= {2'h2, ~eoe};
      wr_reg(`PORT_D_DIR_OFS, m);
      idle(3);
      rd_reg(`PORT_D_DIR_OFS, m);
      rd_reg(`PORT_D_DATA_OFS, (m & v) | (~m & ((eoe & eo) | (~eoe & p))));
      settle();
      check("port d enable", eoe, pd_oe);
      check("port d out", eoe & eo, eoe & pd_out);
      check("port d pull", mk & ~le, pd_pd);
      check("link data in", mk & ((eoe & eo) | (~eoe & p)), link_in);
      check("port c roles", 8'h09, {4'h0, pc_pd, pc_oe});
      check("link clock", {7'h00, w[0]}, {7'h00, pc_out[0]});
      check("link interrupt", {7'h00, p[0]}, {7'h00, link_int});
      @(posedge clk);
    end
    link_en <= 1'b0;
    settle();
    check("port c enable", 8'h03, {6'h00, pc_oe});
    check("port c out", {6'h00, pc_data}, {6'h00, pc_out});
    @(posedge clk);
    pa_pin <= 6'h2A;
    idle(3);
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    wr_reg(`PORT_A_SAMPLE_OFS, 8'hFF);
    rd_reg(`PORT_A_SAMPLE_OFS, 8'h2A);
    rd_reg(`PORT_D_DIR_OFS, 8'h00);
    pa_pin <= 6'h15;
    rd_reg(`PORT_A_SAMPLE_OFS, 8'h2A);
    rd_reg(`PORT_A_SAMPLE_OFS, 8'h2A);
    rd_reg(`PORT_A_SAMPLE_OFS, 8'h15);
    idle(2);
    tally_and_finish();
  end
endmodule
